// >>> pkg/bridge_gc_pkg.sv
// Purpose: Shared constants and carrier types for the general control fields
// Assumes: Avalon-MM slave with 32-bit data and byte addresses
// Notes:   All offsets, field positions, reset values and encodings live here
package bridge_gc_pkg;

   // Register byte offsets
   localparam logic [3:0] OFS_GEN_CTRL  = 4'h0;
   localparam logic [3:0] OFS_TL_CTRL   = 4'h4;
   localparam logic [3:0] OFS_LINK_CTRL = 4'h8;
   localparam logic [3:0] OFS_STATUS    = 4'hc;

   // General control field positions
   localparam int GC_PROMOTE_BIT = 24;
   localparam int GC_CPM_DEF_BIT = 23;
   localparam int GC_SLOT_LO     = 20;
   localparam int GC_SLOT_HI     = 22;

   // Other register field positions
   localparam int TL_CACHE_CHECK_BIT = 0;
   localparam int LC_CLOCK_PM_BIT    = 8;
   localparam int ST_PROMOTE_BIT     = 0;
   localparam int ST_PWR_PIN_BIT     = 1;
   localparam int ST_CLK_OFF_BIT     = 2;
   localparam int ST_UR_MODE_BIT     = 3;

   // Byte lanes holding the writable fields
   localparam int LANE_PROMOTE     = 3;
   localparam int LANE_CPM_DEF     = 2;
   localparam int LANE_CACHE_CHECK = 0;
   localparam int LANE_CLOCK_PM    = 1;

   // Reset values
   localparam logic GC_PROMOTE_RST     = 1'b0;
   localparam logic GC_CPM_DEF_RST     = 1'b0;
   localparam logic TL_CACHE_CHECK_RST = 1'b0;
   localparam logic LC_CLOCK_PM_RST    = 1'b0;

   // Slot power response encodings
   typedef enum logic [2:0] {
      SLOT_IGNORE      = 3'b000,
      SLOT_PIN         = 3'b001,
      SLOT_CLK_OFF     = 3'b010,
      SLOT_CLK_OFF_PIN = 3'b011,
      SLOT_UR_ALL      = 3'b100,
      SLOT_RSVD5       = 3'b101,
      SLOT_RSVD6       = 3'b110,
      SLOT_RSVD7       = 3'b111
   } slotResp_t;

   localparam slotResp_t SLOT_RESP_HARDWIRED = SLOT_IGNORE;

   // Upstream memory read command encodings
   localparam logic [1:0] CMD_READ          = 2'h0;
   localparam logic [1:0] CMD_READ_LINE     = 2'h1;
   localparam logic [1:0] CMD_READ_MULTIPLE = 2'h2;

   // Upstream read request from the secondary bus
   typedef struct packed {
      logic       valid;
      logic [1:0] cmd;
      logic       isConfig;
      logic       isSlotPwrMsg;
   } upReq_t;

   // Request as forwarded upstream
   typedef struct packed {
      logic       valid;
      logic [1:0] cmd;
      logic       prefetch;
      logic       unsupported;
   } upFwd_t;

endpackage : bridge_gc_pkg

// >>> rtl/fund_reset_gen.sv
// Purpose: Fundamental reset from the link reset and global reset pins
// Assumes: Pins are active low
// Notes:   Asserts at once, releases two clock edges after both pins rise
`timescale 1ns/10ps
module fund_reset_gen (
   // Clock
   input  wire logic clk,
   // Reset pins
   input  wire logic linkResetPin_b,
   input  wire logic globalResetPin_b,
   // Derived reset
   output      logic fundamentalReset_b
);

   typedef struct packed {
      logic sync1;
      logic sync2;
   } fundamental_reset_t;

   fundamental_reset_t st_r;
   fundamental_reset_t st_nxt;
   logic  pinsIdle_b;

   // Either pin low asserts the fundamental reset
   assign pinsIdle_b = linkResetPin_b & globalResetPin_b;

   always_comb begin
      st_nxt       = st_r;
      st_nxt.sync1 = 1'b1;
      st_nxt.sync2 = st_r.sync1;
   end

   always_ff @(posedge clk or negedge pinsIdle_b) begin
      if (!pinsIdle_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign fundamentalReset_b = st_r.sync2;

endmodule : fund_reset_gen

// >>> rtl/bridge_gc_fields.sv
// Purpose: General control fields of the bridge and their effect on upstream reads
// Assumes: Avalon-MM slave, 32-bit data, byte addresses, inputs synchronous to clk
// Notes:   Promotion and clock power default fields sit in the fundamental reset domain
//
// What this block does
// - With promotion bit clear, upstream memory reads pass with their own command.
// - With promotion bit set, upstream memory reads become read-multiple with prefetch.
// - Promotion acts only while the cache-line-check enable bit is set.
// - Bit 23 gives the power-up default of link control clock power bit 8.
// - Slot power response bits 22:20 are hardwired to read 000b, limit ignored.
// - Codes 001 pin, 010 clocks off, 011 clocks off plus pin.
// - Code 100 refuses all but configuration and slot power messages; 101-111 reserved.
// - Bits 24 to 20 reset only by fundamental reset from either reset pin.
`timescale 1ns/10ps
module bridge_gc_fields
   import bridge_gc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Reset pins
   input  wire logic        linkResetPin_b,
   input  wire logic        globalResetPin_b,
   // Avalon-MM slave
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [3:0]  byteenable,
   input  wire logic [31:0] writedata,
   output      logic [31:0] readdata,
   output      logic        waitrequest,
   // Upstream read path
   input  wire upReq_t      upReq,
   output      upFwd_t      upFwd,
   // Slot power actions
   output      logic        powerOverridePin,
   output      logic        secondaryClockOff,
   // Link control
   output      logic        clockPmEnable
);

   ////////////////////////////////////////////////////////////////////////////////
   // Types and state

   typedef struct packed {
      logic promote;
      logic cpmDefault;
   } fund_t;

   typedef struct packed {
      logic        cacheCheck;
      logic        clockPm;
      logic        cpmLoadPending;
      logic        ack;
      logic [31:0] readData;
      upFwd_t      fwd;
   } core_t;

   fund_t     fund_r;
   fund_t     fund_nxt;
   core_t     core_r;
   core_t     core_nxt;
   logic      fundamentalReset_b;
   logic      wrTaken;
   slotResp_t slotResp;
   logic      promoteActive;
   logic      urMode;

   ////////////////////////////////////////////////////////////////////////////////
   // Helper functions

   function automatic logic laneWrite(input logic [3:0] off, input logic [3:0] lanes,
                                      input int lane);
      laneWrite = (address == off) && lanes[lane];
   endfunction : laneWrite

   function automatic logic slotDrivesPin(input slotResp_t code);
      slotDrivesPin = (code == SLOT_PIN) || (code == SLOT_CLK_OFF_PIN);
   endfunction : slotDrivesPin

   function automatic logic slotStopsClocks(input slotResp_t code);
      slotStopsClocks = (code == SLOT_CLK_OFF) || (code == SLOT_CLK_OFF_PIN);
   endfunction : slotStopsClocks

   ////////////////////////////////////////////////////////////////////////////////
   // Fundamental reset

   fund_reset_gen frstGen (
      .clk                (clk),
      .linkResetPin_b     (linkResetPin_b),
      .globalResetPin_b   (globalResetPin_b),
      .fundamentalReset_b (fundamentalReset_b)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Slot power response decode

   // Field is a constant; writes to it never land
   assign slotResp = SLOT_RESP_HARDWIRED;

   // Pin and clock actions follow the code
   assign powerOverridePin  = slotDrivesPin(slotResp);
   assign secondaryClockOff = slotStopsClocks(slotResp);

   // Only code 100 refuses; reserved codes act as ignore
   assign urMode = (slotResp == SLOT_UR_ALL);

   // Promotion gated by cache-line-check enable
   assign promoteActive = fund_r.promote & core_r.cacheCheck;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus handshake

   assign waitrequest = (read | write) & ~core_r.ack;
   assign wrTaken     = write & core_r.ack;
   assign readdata    = core_r.readData;

   ////////////////////////////////////////////////////////////////////////////////
   // Fundamental reset domain fields

   always_comb begin
      fund_nxt = fund_r;
      if (wrTaken && laneWrite(OFS_GEN_CTRL, byteenable, LANE_PROMOTE)) begin
         fund_nxt.promote = writedata[GC_PROMOTE_BIT];
      end
      if (wrTaken && laneWrite(OFS_GEN_CTRL, byteenable, LANE_CPM_DEF)) begin
         fund_nxt.cpmDefault = writedata[GC_CPM_DEF_BIT];
      end
   end

   // Only the fundamental reset clears these fields
   always_ff @(posedge clk or negedge fundamentalReset_b) begin
      if (!fundamentalReset_b) begin
         fund_r <= '{promote: GC_PROMOTE_RST, cpmDefault: GC_CPM_DEF_RST};
      end else begin
         fund_r <= fund_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Core registers, read data and upstream path

   always_comb begin
      core_nxt     = core_r;
      core_nxt.ack = (read | write) & ~core_r.ack;

      // Read word captured one cycle ahead of the answer
      if (read && !core_r.ack) begin
         core_nxt.readData = 32'h0000_0000;
         case (address)
            OFS_GEN_CTRL: begin
               core_nxt.readData[GC_PROMOTE_BIT]         = fund_r.promote;
               core_nxt.readData[GC_CPM_DEF_BIT]         = fund_r.cpmDefault;
               core_nxt.readData[GC_SLOT_HI:GC_SLOT_LO]  = slotResp;
            end
            OFS_TL_CTRL: begin
               core_nxt.readData[TL_CACHE_CHECK_BIT] = core_r.cacheCheck;
            end
            OFS_LINK_CTRL: begin
               core_nxt.readData[LC_CLOCK_PM_BIT] = core_r.clockPm;
            end
            OFS_STATUS: begin
               core_nxt.readData[ST_PROMOTE_BIT] = promoteActive;
               core_nxt.readData[ST_PWR_PIN_BIT] = powerOverridePin;
               core_nxt.readData[ST_CLK_OFF_BIT] = secondaryClockOff;
               core_nxt.readData[ST_UR_MODE_BIT] = urMode;
            end
            default: begin
               core_nxt.readData = 32'h0000_0000;
            end
         endcase
      end

      if (wrTaken && laneWrite(OFS_TL_CTRL, byteenable, LANE_CACHE_CHECK)) begin
         core_nxt.cacheCheck = writedata[TL_CACHE_CHECK_BIT];
      end

      // Power-up default taken once after reset, then software owns the bit
      if (core_r.cpmLoadPending) begin
         core_nxt.clockPm        = fund_r.cpmDefault;
         core_nxt.cpmLoadPending = 1'b0;
      end else if (wrTaken && laneWrite(OFS_LINK_CTRL, byteenable, LANE_CLOCK_PM)) begin
         core_nxt.clockPm = writedata[LC_CLOCK_PM_BIT];
      end

      // Upstream memory read forwarding
      core_nxt.fwd.valid       = upReq.valid;
      core_nxt.fwd.cmd         = upReq.cmd;
      core_nxt.fwd.prefetch    = (upReq.cmd != CMD_READ);
      core_nxt.fwd.unsupported = 1'b0;
      if (promoteActive) begin
         core_nxt.fwd.cmd      = CMD_READ_MULTIPLE;
         core_nxt.fwd.prefetch = 1'b1;
      end
      if (urMode && !upReq.isConfig && !upReq.isSlotPwrMsg) begin
         core_nxt.fwd.unsupported = upReq.valid;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         core_r                <= '0;
         core_r.cacheCheck     <= TL_CACHE_CHECK_RST;
         core_r.clockPm        <= LC_CLOCK_PM_RST;
         core_r.cpmLoadPending <= 1'b1;
      end else begin
         core_r <= core_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign upFwd         = core_r.fwd;
   assign clockPmEnable = core_r.clockPm;

endmodule : bridge_gc_fields

// >>> testbench/bridge_gc_monitor.sv
// Purpose: Port checker for the general control fields
// Assumes: One clock, rst_b active low
// Notes:   Bound to every bridge_gc_fields instance
`timescale 1ns/10ps
module bridge_gc_monitor
   import bridge_gc_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_b,
   // Register bus
   input wire logic [3:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   // Upstream path and outputs
   input wire upReq_t      upReq,
   input wire upFwd_t      upFwd,
   input wire logic        powerOverridePin,
   input wire logic        secondaryClockOff,
   input wire logic        clockPmEnable
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic rdDone;
   logic lcWr;
   assign rdDone = read && !waitrequest;
   assign lcWr   = write && !waitrequest && address == OFS_LINK_CTRL;
   ////////////////////////////////////////////////////////////////////////////
   a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("bus wait not one cycle");
   a_slot_read: assert property (rdDone && address == OFS_GEN_CTRL |->
      readdata[GC_SLOT_HI:GC_SLOT_LO] == 3'b000) else $error("slot field not zero");
   a_unmapped_zero: assert property (rdDone && address[1:0] != 2'b00 |-> readdata == 32'h0)
      else $error("unmapped read not zero");
   a_pin_off: assert property (!powerOverridePin) else $error("override pin set");
   a_clk_on: assert property (!secondaryClockOff) else $error("clocks off");
   a_fwd_valid: assert property (1'b1 |=> upFwd.valid == $past(upReq.valid))
      else $error("forward valid wrong");
   a_fwd_cmd: assert property (upReq.valid |=> upFwd.cmd == $past(upReq.cmd) ||
      upFwd.cmd == CMD_READ_MULTIPLE && upFwd.prefetch) else $error("forward cmd wrong");
   a_plain_nopf: assert property (upFwd.valid && !upFwd.prefetch |->
      upFwd.cmd == CMD_READ) else $error("prefetch missing");
   a_no_unsup: assert property (upFwd.valid |-> !upFwd.unsupported)
      else $error("unsupported flagged");
   a_pm_hold: assert property ($past(rst_b) && !lcWr |=> $stable(clockPmEnable))
      else $error("clock pm changed");
   c_promote: cover property (upFwd.valid && upFwd.cmd == CMD_READ_MULTIPLE && upFwd.prefetch);
   c_gen_read: cover property (rdDone && address == OFS_GEN_CTRL);
   c_write: cover property (write && !waitrequest);
endmodule : bridge_gc_monitor
bind bridge_gc_fields bridge_gc_monitor u_mon (.clk, .rst_b, .address, .read, .write,
   .readdata, .waitrequest, .upReq, .upFwd, .powerOverridePin, .secondaryClockOff,
   .clockPmEnable);

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench for the general control fields
// Assumes: Bus access waits on waitrequest
// Notes:   Register content checked on bits 24:20, status and the link control word
`timescale 1ns/10ps
module tb_top
   import bridge_gc_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst_b, linkResetPin_b, globalResetPin_b, read, write;
   logic [3:0]  address, byteenable;
   logic [31:0] writedata, readdata, q;
   logic        waitrequest, powerOverridePin, secondaryClockOff, clockPmEnable;
   upReq_t      upReq;
   upFwd_t      upFwd;
   int          fails = 0;
   int          n_tests = 0;
   always #4 clk = ~clk;
   bridge_gc_fields uut (.clk, .rst_b, .linkResetPin_b, .globalResetPin_b, .address, .read,
      .write, .byteenable, .writedata, .readdata, .waitrequest, .upReq, .upFwd,
      .powerOverridePin, .secondaryClockOff, .clockPmEnable);
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      address   <= a;
      read      <= !w;
      write     <= w;
      writedata <= d;
      // Request held until the edge that samples waitrequest low; the watchdog ends a hang
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      q = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask : acc
   task automatic up(input logic [1:0] c, input logic [1:0] ec, input logic epf);
      @(posedge clk);
      upReq <= '{1'b1, c, 1'b0, 1'b0};
      @(posedge clk);
      upReq <= '0;
      @(negedge clk);
      chk("fwd cmd", {upFwd.valid, upFwd.cmd}, {1'b1, ec});
      chk("fwd flags", {upFwd.prefetch, upFwd.unsupported}, {epf, 1'b0});
   endtask : up
   task automatic fpulse(input logic g);
      @(posedge clk);
      if (g) globalResetPin_b <= 1'b0;
      else linkResetPin_b <= 1'b0;
      repeat (2) @(posedge clk);
      linkResetPin_b   <= 1'b1;
      globalResetPin_b <= 1'b1;
      repeat (4) @(posedge clk);
   endtask : fpulse
   task automatic summarize;
      $display("Checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      fails++;
      summarize();
   end
   initial begin
      rst_b = 1'b0;
      linkResetPin_b = 1'b0;
      globalResetPin_b = 1'b0;
      {read, write, address, writedata, upReq} = '0;
      byteenable = 4'hf;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      linkResetPin_b <= 1'b1;
      globalResetPin_b <= 1'b1;
      repeat (4) @(posedge clk);
      acc(1'b0, OFS_GEN_CTRL, 32'h0);
      chk("gen 24:20", q[24:20], 32'h0);
      chk("clock pm", clockPmEnable, 32'h0);
      up(CMD_READ, CMD_READ, 1'b0);
      up(CMD_READ_LINE, CMD_READ_LINE, 1'b1);
      acc(1'b1, OFS_GEN_CTRL, 32'hffffffff);
      acc(1'b0, OFS_GEN_CTRL, 32'h0);
      chk("gen 24:20", q[24:20], 32'h18);
      chk("slot pins", {powerOverridePin, secondaryClockOff}, 32'h0);
      up(CMD_READ, CMD_READ, 1'b0);
      acc(1'b1, OFS_TL_CTRL, 32'h1);
      for (int c = 0; c < 3; c++) up(c[1:0], CMD_READ_MULTIPLE, 1'b1);
      acc(1'b0, OFS_STATUS, 32'h0);
      chk("status", q[3:0], 32'h1);
      acc(1'b0, 4'h2, 32'h0);
      @(posedge clk);
      rst_b <= 1'b0;
      @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("clock pm", clockPmEnable, 32'h1);
      acc(1'b0, OFS_LINK_CTRL, 32'h0);
      chk("link ctrl", q, 32'h0000_0100);
      acc(1'b0, OFS_GEN_CTRL, 32'h0);
      chk("gen 24:20", q[24:20], 32'h18);
      acc(1'b1, OFS_LINK_CTRL, 32'h0);
      @(negedge clk);
      chk("clock pm", clockPmEnable, 32'h0);
      fpulse(1'b0);
      acc(1'b0, OFS_GEN_CTRL, 32'h0);
      chk("gen 24:20", q[24:20], 32'h0);
      // Lanes 3 and 2 disabled: promotion and clock default bits must not move
      byteenable <= 4'h3;
      acc(1'b1, OFS_GEN_CTRL, 32'hffffffff);
      byteenable <= 4'hf;
      acc(1'b0, OFS_GEN_CTRL, 32'h0);
      chk("gen lanes", q[24:20], 32'h0);
      acc(1'b1, OFS_GEN_CTRL, 32'hffffffff);
      fpulse(1'b1);
      acc(1'b0, OFS_GEN_CTRL, 32'h0);
      chk("gen 24:20", q[24:20], 32'h0);
      summarize();
   end
endmodule : tb_top
